// File: spmc_cfg.svh
// constants for the stop and power mode controller: register indices, bit positions, timing
// assumes inclusion by bare name from the package and the design modules
`ifndef SPMC_CFG_SVH
`define SPMC_CFG_SVH
`define SPMC_IDX_GLOBAL_CONFIGURATION 8'h00
`define SPMC_IDX_INSTAT 8'h04
`define SPMC_IDX_DRVCONF 8'h05
`define SPMC_IDX_HOLDRUN 8'h12
`define SPMC_IDX_ENCODER_MODE 8'h2f
`define SPMC_IDX_CHOPPER_PWM_CONFIGURATION 8'h3c
`define SPMC_IDX_ENCCONST 8'h3a
`define SPMC_GC_DRV_DISABLE 0
`define SPMC_GC_STOP_ENABLE 1
`define SPMC_GC_QSC_REQ 2
`define SPMC_DC_HALT_EN 0
`define SPMC_DC_SRC_LSB 1
`define SPMC_DC_SRC_MSB 2
`define SPMC_EM_QSC_ENC 15
`define SPMC_IS_ENC_A 0
`define SPMC_IS_LEFT 1
`define SPMC_IS_RIGHT 2
`define SPMC_IS_QSC 15
`define SPMC_HR_HOLD_LSB 0
`define SPMC_HR_HOLD_MSB 4
`define SPMC_HR_DLY_LSB 16
`define SPMC_HR_DLY_MSB 19
`define SPMC_PC_FW_LSB 20
`define SPMC_PC_FW_MSB 21
`define SPMC_ENC_DEC_ONE 32'h0001_0000
`define SPMC_ENC_DEC_TENK 16'h2710
`define SPMC_RST_MIN_NS 30000
`define SPMC_FILT_NS 50000
`define SPMC_CLK_MHZ 250
`define SPMC_RST_MIN_CYC ((`SPMC_RST_MIN_NS * `SPMC_CLK_MHZ + 999) / 1000)
`define SPMC_FILT_CYC ((`SPMC_FILT_NS * `SPMC_CLK_MHZ) / 1000)
`endif

// File: spmc_pin_model.sv
// system side: stop pin, limit switches, sleep input, motor motion
// assumes calls from the bench; pins move 1 ns after the clock edge
`timescale 1ns/1ns
`default_nettype none
module spmc_pin_model (
   input wire logic sys_clk,
   input wire logic bridge_enable,
   output logic enc_a_in,
   output logic left_limit_input,
   output logic right_limit_input,
   output logic sleep_reset_input_n,
   output logic motor_standstill
);
   logic moving = 1'b0;
   logic [1:0] coast_q = 2'h0;
   initial begin
      enc_a_in = 1'b0;
      left_limit_input = 1'b0;
      right_limit_input = 1'b0;
      sleep_reset_input_n = 1'b1;
   end
   task automatic set_pins(input logic a, input logic l, input logic r, input logic s);
      @(posedge sys_clk);
      #1;
      enc_a_in = a;
      left_limit_input = l;
      right_limit_input = r;
      sleep_reset_input_n = s;
   endtask
   task automatic set_motion(input logic m);
      @(posedge sys_clk);
      #1;
      moving = m;
   endtask
   // rotor coasts a few cycles, so standstill never follows the stop at once
   always @(posedge sys_clk) begin
      if (moving && bridge_enable) coast_q <= 2'h3;
      else if (coast_q != 2'h0) coast_q <= coast_q - 2'h1;
   end
   assign motor_standstill = (coast_q == 2'h0);
endmodule
`default_nettype wire

// File: spmc_pkg.sv
// types shared by the stop and power mode controller modules
// assumes spmc_cfg.svh is on the include path
`include "spmc_cfg.svh"
package spmc_pkg;
   typedef enum logic [1:0] {
      spmc_run,
      spmc_wait_stst,
      spmc_quiet
   } spmc_qstate_t;
   typedef logic [7:0] spmc_addr_t;
   typedef logic [31:0] spmc_word_t;
endpackage

// File: spmc_sleep_filter.sv
// filter for the active-low sleep/reset input
// assumes the input is synchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
`include "spmc_cfg.svh"
module spmc_sleep_filter #(
   parameter int RST_CYC = `SPMC_RST_MIN_CYC,
   parameter int FILT_CYC = `SPMC_FILT_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic sleep_reset_input_n,
   spmc_sleep_if.filt sif
);
   logic [15:0] low_cnt_q;
   logic reset_req_q;
   logic driver_off_q;
   logic asleep_q;
   wire logic at_rst = (low_cnt_q >= 16'(RST_CYC));
   wire logic at_filt = (low_cnt_q >= 16'(FILT_CYC));
   // count the length of the low level; short glitches never reach the threshold
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt_q <= 16'h0000;
      end else if (sleep_reset_input_n) begin
         low_cnt_q <= 16'h0000;
      end else if (!at_filt) begin
         low_cnt_q <= low_cnt_q + 16'h0001;
      end
   end
   // reset held while low past the threshold; released with the pin
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reset_req_q <= 1'b0;
         driver_off_q <= 1'b0;
         asleep_q <= 1'b0;
      end else begin
         reset_req_q <= !sleep_reset_input_n && at_rst;
         driver_off_q <= !sleep_reset_input_n && at_filt;
         asleep_q <= !sleep_reset_input_n && at_filt;
      end
   end
   assign sif.reset_req = reset_req_q;
   assign sif.driver_off = driver_off_q;
   assign sif.asleep = asleep_q;
endmodule
`default_nettype wire

// File: spmc_sleep_if.sv
// carrier between the sleep filter and the main controller
// assumes both ends share sys_clk
`timescale 1ns/1ns
`default_nettype none
interface spmc_sleep_if;
   logic reset_req;
   logic driver_off;
   logic asleep;
   modport filt (output reset_req, output driver_off, output asleep);
   modport ctrl (input reset_req, input driver_off, input asleep);
endinterface
`default_nettype wire

// File: spmc_top.sv
// stop and power mode controller: register file plus driver gating
// assumes a serial front end delivering word accesses with a one-cycle strobe
//
// Summary of operation
// - decimal scale holds integer times 65536 plus fraction in ten-thousandths
// - setting driver-disable switches off every output transistor at once
// - clearing driver-disable releases the stop; registers and serial port stay alive
// - pin-stop enable makes encoder A a stop request
// - while enabled stop pin is high the motor is halted
// - pin stop enters standstill power-down with hold current, delay, freewheel option
// - stop pin low again resumes normal operation
// - hard stop armed only by its enable bit; source select is only passed out on hard_halt_source_select
// - both limit inputs high disable driver; released when both are low
// - quiescence request enters low power at standstill, disabling driver
// - input status bit 15 reads one while quiescence is active
// - encoder keeps running in quiescence only when its keep bit is set
// - sleep input low over 30 us resets registers; driver off after 50 us
// - sleep input held low keeps registers at default, serial off, driver off
// - shorter sleep input pulses are ignored
`timescale 1ns/1ns
`default_nettype none
`include "spmc_cfg.svh"
module spmc_top #(
   parameter int RST_CYC = `SPMC_RST_MIN_CYC,
   parameter int FILT_CYC = `SPMC_FILT_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire spmc_pkg::spmc_addr_t reg_addr,
   input wire spmc_pkg::spmc_word_t reg_wdata,
   output spmc_pkg::spmc_word_t reg_rdata,
   output logic reg_rvalid,
   input wire logic enc_a_in,
   input wire logic left_limit_input,
   input wire logic right_limit_input,
   input wire logic sleep_reset_input_n,
   input wire logic motor_standstill,
   output logic bridge_enable,
   output logic standstill_req,
   output logic [4:0] hold_current_level,
   output logic [3:0] hold_ramp_delay,
   output logic [1:0] freewheel_mode,
   output logic encoder_enable,
   output logic quiescence_active,
   output logic serial_active,
   output logic [1:0] hard_halt_source_select,
   output spmc_pkg::spmc_word_t encoder_scale_constant
);
   spmc_sleep_if sif ();

   spmc_sleep_filter #(
      .RST_CYC(RST_CYC),
      .FILT_CYC(FILT_CYC)
   ) u_filt (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .sleep_reset_input_n(sleep_reset_input_n),
      .sif(sif)
   );

   spmc_pkg::spmc_word_t global_configuration_q;
   spmc_pkg::spmc_word_t drvconf_q;
   spmc_pkg::spmc_word_t holdrun_q;
   spmc_pkg::spmc_word_t encoder_mode_q;
   spmc_pkg::spmc_word_t chopper_pwm_configuration_q;
   spmc_pkg::spmc_word_t encconst_q;
   spmc_pkg::spmc_qstate_t qst_q;
   spmc_pkg::spmc_qstate_t qst_d;
   spmc_pkg::spmc_word_t rdata_q;
   logic rvalid_q;
   logic hard_latch_q;
   logic bridge_q;
   logic stst_req_q;
   logic enc_en_q;
   logic qsc_q;
   logic serial_q;

   // registers fall back to defaults on the filtered sleep reset
   wire logic soft_rst = sif.reset_req;
   wire logic port_on = !sif.reset_req && !sif.asleep;
   wire logic wr_en = reg_wr && port_on;
   wire logic rd_en = reg_rd && port_on;

   function automatic logic hit(input spmc_pkg::spmc_addr_t a, input spmc_pkg::spmc_addr_t idx);
      hit = wr_en && (a == idx);
   endfunction

   // decimal mode helper: integer and ten-thousandths into the 16.16 word
   function automatic spmc_pkg::spmc_word_t dec_scale(input logic [15:0] ip, input logic [15:0] fr);
      dec_scale = 32'(ip * `SPMC_ENC_DEC_ONE) + 32'(fr);
   endfunction

   // control bits pulled out of the register words
   wire logic drv_disable = global_configuration_q[`SPMC_GC_DRV_DISABLE];
   wire logic stop_en = global_configuration_q[`SPMC_GC_STOP_ENABLE];
   wire logic qsc_req = global_configuration_q[`SPMC_GC_QSC_REQ];
   wire logic halt_en = drvconf_q[`SPMC_DC_HALT_EN];
   wire logic qsc_enc_keep = encoder_mode_q[`SPMC_EM_QSC_ENC];

   // stop conditions
   wire logic pin_stop = stop_en && enc_a_in;
   wire logic both_hi = left_limit_input && right_limit_input;
   wire logic both_lo = !left_limit_input && !right_limit_input;
   wire logic qsc_on = (qst_q == spmc_pkg::spmc_quiet);

   // driver-disable, hard stop latch, quiescence or sleep keeps the bridge off; all must clear
   wire logic bridge_d = !(drv_disable || hard_latch_q || qsc_on || sif.driver_off);

   // register writes; the serial port is blocked while the sleep reset holds
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         global_configuration_q <= 32'h0000_0000;
      end else if (soft_rst) begin
         global_configuration_q <= 32'h0000_0000;
      end else if (hit(reg_addr, `SPMC_IDX_GLOBAL_CONFIGURATION)) begin
         global_configuration_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         drvconf_q <= 32'h0000_0000;
      end else if (soft_rst) begin
         drvconf_q <= 32'h0000_0000;
      end else if (hit(reg_addr, `SPMC_IDX_DRVCONF)) begin
         drvconf_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         holdrun_q <= 32'h0000_0000;
      end else if (soft_rst) begin
         holdrun_q <= 32'h0000_0000;
      end else if (hit(reg_addr, `SPMC_IDX_HOLDRUN)) begin
         holdrun_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         encoder_mode_q <= 32'h0000_0000;
      end else if (soft_rst) begin
         encoder_mode_q <= 32'h0000_0000;
      end else if (hit(reg_addr, `SPMC_IDX_ENCODER_MODE)) begin
         encoder_mode_q <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         chopper_pwm_configuration_q <= 32'h0000_0000;
      end else if (soft_rst) begin
         chopper_pwm_configuration_q <= 32'h0000_0000;
      end else if (hit(reg_addr, `SPMC_IDX_CHOPPER_PWM_CONFIGURATION)) begin
         chopper_pwm_configuration_q <= reg_wdata;
      end
   end

   // scale is stored as written; software does the division itself
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         encconst_q <= `SPMC_ENC_DEC_ONE;
      end else if (soft_rst) begin
         encconst_q <= dec_scale(16'h0001, 16'h0000); // decimal 1.0
      end else if (hit(reg_addr, `SPMC_IDX_ENCCONST)) begin
         encconst_q <= reg_wdata;
      end
   end

   // hard stop latches on both high, releases when both low, when its enable bit is cleared or on the sleep reset
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hard_latch_q <= 1'b0;
      end else if (!halt_en || soft_rst) begin
         hard_latch_q <= 1'b0;
      end else if (both_hi) begin
         hard_latch_q <= 1'b1;
      end else if (both_lo) begin
         hard_latch_q <= 1'b0;
      end
   end

   // quiescence sequencing: wait for standstill before going quiet
   always_comb begin
      qst_d = qst_q;
      unique case (qst_q)
         spmc_pkg::spmc_run: begin
            if (qsc_req) begin
               qst_d = spmc_pkg::spmc_wait_stst;
            end
         end
         spmc_pkg::spmc_wait_stst: begin
            if (!qsc_req) begin
               qst_d = spmc_pkg::spmc_run;
            end else if (motor_standstill) begin
               qst_d = spmc_pkg::spmc_quiet;
            end
         end
         spmc_pkg::spmc_quiet: begin
            if (!qsc_req) begin
               qst_d = spmc_pkg::spmc_run;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         qst_q <= spmc_pkg::spmc_run;
      end else if (soft_rst) begin
         qst_q <= spmc_pkg::spmc_run;
      end else begin
         qst_q <= qst_d;
      end
   end

   // software clears driver-disable itself once quiescence is left
   // read mux over the mapped indices; unmapped reads return zero
   wire spmc_pkg::spmc_word_t instat_w = {16'h0000, qsc_on, 12'h000, right_limit_input,
      left_limit_input, enc_a_in} ;
   wire spmc_pkg::spmc_word_t rd_mux =
      (reg_addr == `SPMC_IDX_GLOBAL_CONFIGURATION) ? global_configuration_q :
      (reg_addr == `SPMC_IDX_INSTAT) ? instat_w :
      (reg_addr == `SPMC_IDX_DRVCONF) ? drvconf_q :
      (reg_addr == `SPMC_IDX_HOLDRUN) ? holdrun_q :
      (reg_addr == `SPMC_IDX_ENCODER_MODE) ? encoder_mode_q :
      (reg_addr == `SPMC_IDX_CHOPPER_PWM_CONFIGURATION) ? chopper_pwm_configuration_q :
      (reg_addr == `SPMC_IDX_ENCCONST) ? encconst_q : 32'h0000_0000;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rd_en ? rd_mux : rdata_q;
         rvalid_q <= rd_en;
      end
   end

   // driver-facing outputs, all registered
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bridge_q <= 1'b0;
         stst_req_q <= 1'b0;
         enc_en_q <= 1'b1;
         qsc_q <= 1'b0;
         serial_q <= 1'b1;
      end else begin
         bridge_q <= bridge_d;
         stst_req_q <= pin_stop;
         enc_en_q <= !qsc_on || qsc_enc_keep;
         qsc_q <= qsc_on;
         serial_q <= port_on;
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign bridge_enable = bridge_q;
   assign standstill_req = stst_req_q;
   assign hold_current_level = holdrun_q[`SPMC_HR_HOLD_MSB:`SPMC_HR_HOLD_LSB];
   assign hold_ramp_delay = holdrun_q[`SPMC_HR_DLY_MSB:`SPMC_HR_DLY_LSB];
   assign freewheel_mode = chopper_pwm_configuration_q[`SPMC_PC_FW_MSB:`SPMC_PC_FW_LSB];
   assign hard_halt_source_select = drvconf_q[`SPMC_DC_SRC_MSB:`SPMC_DC_SRC_LSB];
   assign encoder_enable = enc_en_q;
   assign quiescence_active = qsc_q;
   assign serial_active = serial_q;
   assign encoder_scale_constant = encconst_q;
endmodule
`default_nettype wire

// File: spmc_top_props.sv
// port checker for the stop and power mode controller
// assumes one sys_clk domain and binding onto spmc_top
`timescale 1ns/1ns
`default_nettype none
module spmc_top_props #(
   parameter int RST_CYC = 4,
   parameter int FILT_CYC = 8
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire spmc_pkg::spmc_addr_t reg_addr,
   input wire spmc_pkg::spmc_word_t reg_wdata,
   input wire spmc_pkg::spmc_word_t reg_rdata,
   input wire logic reg_rvalid,
   input wire logic enc_a_in,
   input wire logic sleep_reset_input_n,
   input wire logic motor_standstill,
   input wire logic bridge_enable,
   input wire logic standstill_req,
   input wire logic quiescence_active,
   input wire logic serial_active
);
   logic [7:0] low_q;
   logic [7:0] low_d;
   // saturating count of low sleep cycles; zero means the port is live
   assign low_d = sleep_reset_input_n ? 8'h00 : (low_q == 8'hff ? low_q : low_q + 8'h01);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         low_q <= 8'h00;
      end else begin
         low_q <= low_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence off_write;
      reg_wr && reg_addr == 8'h00 && reg_wdata[0] && low_q == 8'h00;
   endsequence
   sequence live_read;
      reg_rd && low_q == 8'h00;
   endsequence
   // status read: rdata and the quiescence flag sample the same state on the same edge
   sequence status_read;
      reg_rd && low_q == 8'h00 && reg_addr == 8'h04;
   endsequence
   chk_sw_stop_off: assert property (off_write |-> ##2 !bridge_enable)
      else $error("bridge on after disable write");
   chk_read_answer: assert property (live_read |=> reg_rvalid)
      else $error("read not answered");
   chk_rvalid_cause: assert property (!reg_rd |=> !reg_rvalid)
      else $error("rvalid without read");
   chk_status_bit: assert property (status_read |=> reg_rdata[15] == quiescence_active)
      else $error("status bit differs from quiescence");
   chk_pin_cause: assert property (standstill_req |-> enc_a_in || $past(enc_a_in) || $past(enc_a_in, 2))
      else $error("pin stop without pin");
   // state moves on the standstill seen two edges back, the flag follows one later
   chk_quiet_entry: assert property ($rose(quiescence_active) |-> $past(motor_standstill, 2))
      else $error("quiescence before standstill");
   chk_quiet_drv: assert property (quiescence_active && $past(quiescence_active) |-> !bridge_enable)
      else $error("bridge on in quiescence");
   chk_sleep_off: assert property (low_q > FILT_CYC + 2 |-> !bridge_enable && !serial_active)
      else $error("bridge or serial on in sleep");
endmodule
bind spmc_top spmc_top_props #(.RST_CYC(RST_CYC), .FILT_CYC(FILT_CYC)) u_spmc_top_props (
   .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .enc_a_in(enc_a_in),
   .sleep_reset_input_n(sleep_reset_input_n), .motor_standstill(motor_standstill),
   .bridge_enable(bridge_enable), .standstill_req(standstill_req),
   .quiescence_active(quiescence_active), .serial_active(serial_active)
);
`default_nettype wire

// File: spmc_top_test.sv
// bench for the stop and power mode controller
// assumes the pin model drives all pins; short filter counts
`timescale 1ns/1ns
`default_nettype none
`include "spmc_cfg.svh"
module spmc_top_test;
   localparam int RST_CYC = 4;
   localparam int FILT_CYC = 8;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   spmc_pkg::spmc_addr_t reg_addr = 8'h00;
   spmc_pkg::spmc_word_t reg_wdata = 32'h0;
   spmc_pkg::spmc_word_t reg_rdata, encoder_scale_constant, rdv, scale;
   logic reg_rvalid, enc_a_in, left_limit_input, right_limit_input, sleep_reset_input_n, motor_standstill;
   logic bridge_enable, standstill_req, encoder_enable, quiescence_active, serial_active;
   logic [4:0] hold_current_level;
   logic [3:0] hold_ramp_delay;
   logic [1:0] freewheel_mode, hard_halt_source_select;
   int n_errors = 0;
   int checks = 0;
   int cyc = 0;
   always #2 sys_clk = ~sys_clk;
   spmc_top #(.RST_CYC(RST_CYC), .FILT_CYC(FILT_CYC)) u_spmc_top (
      .sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .enc_a_in(enc_a_in),
      .left_limit_input(left_limit_input), .right_limit_input(right_limit_input),
      .sleep_reset_input_n(sleep_reset_input_n), .motor_standstill(motor_standstill),
      .bridge_enable(bridge_enable), .standstill_req(standstill_req), .hold_current_level(hold_current_level),
      .hold_ramp_delay(hold_ramp_delay), .freewheel_mode(freewheel_mode), .encoder_enable(encoder_enable),
      .quiescence_active(quiescence_active), .serial_active(serial_active),
      .hard_halt_source_select(hard_halt_source_select), .encoder_scale_constant(encoder_scale_constant)
   );
   spmc_pin_model u_spmc_pin_model (
      .sys_clk(sys_clk), .bridge_enable(bridge_enable), .enc_a_in(enc_a_in),
      .left_limit_input(left_limit_input), .right_limit_input(right_limit_input),
      .sleep_reset_input_n(sleep_reset_input_n), .motor_standstill(motor_standstill)
   );
   task automatic summarize;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input spmc_pkg::spmc_word_t got, input spmc_pkg::spmc_word_t exp, input string what);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp, input string what);
      cmp({31'h0, got}, {31'h0, exp}, what);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input spmc_pkg::spmc_addr_t a, input spmc_pkg::spmc_word_t d);
      tick(1);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      tick(1);
      reg_wr = 1'b0;
   endtask
   // read answer is taken at the edge after the strobe
   task automatic rd(input spmc_pkg::spmc_addr_t a);
      tick(1);
      reg_rd = 1'b1;
      reg_addr = a;
      tick(1);
      reg_rd = 1'b0;
      cmp1(reg_rvalid, 1'b1, "read valid");
      rdv = reg_rdata;
   endtask
   task automatic rdc(input spmc_pkg::spmc_addr_t a, input spmc_pkg::spmc_word_t exp, input string what);
      rd(a);
      cmp(rdv, exp, what);
   endtask
   // hang guard: the whole sequence needs little more than a hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         summarize;
      end
   end
   initial begin
      tick(3);
      resetn = 1'b1;
      tick(1);
      cmp1(bridge_enable, 1'b1, "bridge at reset");
      cmp1(serial_active, 1'b1, "serial at reset");
      cmp(encoder_scale_constant, `SPMC_ENC_DEC_ONE, "scale at reset");
      rdc(8'h01, 32'h0, "unmapped read");
      // 200 full steps, 256 microsteps, 1000 counts: decimal factor 51.2
      scale = ((200 * 256 / 1000) << 16) + (200 * 256 % 1000) * 10000 / 1000;
      wr(`SPMC_IDX_ENCCONST, scale);
      cmp(encoder_scale_constant, 32'h0033_07d0, "decimal scale");
      $display("test reset_scale done");
      wr(8'h00, 32'h1);
      tick(1);
      cmp1(bridge_enable, 1'b0, "sw stop");
      rdc(8'h00, 32'h1, "global_configuration kept");
      wr(8'h00, 32'h0);
      tick(1);
      cmp1(bridge_enable, 1'b1, "sw release");
      $display("test sw_stop done");
      wr(8'h12, 32'h000a_0003);
      wr(8'h3c, 32'h0010_0000);
      u_spmc_pin_model.set_pins(1'b1, 1'b0, 1'b0, 1'b1);
      tick(3);
      cmp1(standstill_req, 1'b0, "pin not enabled");
      wr(8'h00, 32'h2);
      tick(3);
      cmp1(standstill_req, 1'b1, "pin stop");
      // hold 3, delay 0xa, freewheel 1 packed as 5/4/2 bits
      cmp({21'h0, hold_current_level, hold_ramp_delay, freewheel_mode}, 32'h0000_00e9, "hold setup");
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      tick(3);
      cmp1(standstill_req, 1'b0, "pin resume");
      $display("test pin_stop done");
      u_spmc_pin_model.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
      tick(3);
      cmp1(bridge_enable, 1'b1, "halt unarmed");
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      wr(8'h05, 32'h5);
      cmp({30'h0, hard_halt_source_select}, 32'h2, "halt source");
      u_spmc_pin_model.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
      tick(3);
      cmp1(bridge_enable, 1'b0, "halt both high");
      // one limit low must not release the latch; checked before any other stop is set
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
      tick(2);
      cmp1(bridge_enable, 1'b0, "halt one high");
      wr(8'h00, 32'h1);
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      tick(3);
      cmp1(bridge_enable, 1'b0, "sw stop remains");
      wr(8'h00, 32'h0);
      tick(1);
      cmp1(bridge_enable, 1'b1, "all released");
      $display("test hard_halt done");
      wr(`SPMC_IDX_ENCODER_MODE, 32'h0000_8000);
      u_spmc_pin_model.set_motion(1'b1);
      wr(8'h00, 32'h4);
      tick(4);
      cmp1(quiescence_active, 1'b0, "waits standstill");
      u_spmc_pin_model.set_motion(1'b0);
      tick(8);
      cmp1(quiescence_active, 1'b1, "quiet entered");
      cmp1(bridge_enable, 1'b0, "quiet bridge off");
      cmp1(encoder_enable, 1'b1, "encoder kept");
      rd(8'h04);
      cmp1(rdv[15], 1'b1, "quiet status");
      wr(`SPMC_IDX_ENCODER_MODE, 32'h0);
      tick(1);
      cmp1(encoder_enable, 1'b0, "encoder off in quiet");
      wr(8'h00, 32'h1);
      tick(3);
      cmp1(quiescence_active, 1'b0, "quiet left");
      wr(8'h00, 32'h0);
      tick(1);
      cmp1(bridge_enable, 1'b1, "second write enables");
      $display("test quiescence done");
      wr(8'h00, 32'h2);
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      rdc(8'h00, 32'h2, "short pulse ignored");
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b0);
      tick(FILT_CYC + 4);
      wr(8'h00, 32'h1);
      cmp1(bridge_enable, 1'b0, "sleep bridge off");
      cmp1(serial_active, 1'b0, "sleep serial off");
      u_spmc_pin_model.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
      tick(4);
      rdc(8'h00, 32'h0, "global_configuration default");
      cmp(encoder_scale_constant, `SPMC_ENC_DEC_ONE, "scale default");
      $display("test sleep done");
      summarize;
   end
endmodule
`default_nettype wire
